// ---- include/ntwtr_pkg.sv ----
package ntwtr_pkg;
  // Byte offsets of the bank.
  localparam logic [11:0] OffWin2Xlat = 12'hC3C;
  localparam logic [11:0] OffWin4XlatLo = 12'hC44;
  localparam logic [11:0] OffWin4XlatHi = 12'hC48;
  localparam logic [11:0] OffWin2Lim = 12'hC4C;
  localparam logic [11:0] OffWin4LimLo = 12'hC54;
  localparam logic [11:0] OffWin4LimHi = 12'hC58;
  localparam logic [11:0] OffLutFirst = 12'hC5C;
  localparam logic [11:0] OffLutLast = 12'hD58;
  localparam logic [11:0] OffVc0Res = 12'hD5C;
  localparam logic [11:0] OffVc1Res = 12'hD60;
  localparam logic [11:0] OffVcCap = 12'hD64;
  localparam logic [11:0] OffIoWin1 = 12'hD6C;
  // Field masks.
  localparam logic [31:0] MaskPage = 32'hFFFFF000;
  localparam logic [31:0] MaskLut = 32'hFFFFF009;
  localparam logic [31:0] MaskClassMap = 32'h000000FE;
  localparam logic [31:0] MaskVc1 = 32'h810000FE;
  localparam logic [31:0] MaskIoBase = 32'hFFFFFF00;
  localparam logic [31:0] MaskVcCount = 32'h00000070;
  // Fixed bits and reset values.
  localparam logic [31:0] Vc0Fixed = 32'h80000001;
  localparam logic [31:0] Vc0Reset = 32'h000000FE;
  localparam logic [31:0] Vc1Reset = 32'h01000000;
  localparam logic [31:0] IoSpaceBit = 32'h00000001;
  localparam logic [31:0] ZeroWord = 32'h00000000;
  // Width codes, I/O enable code and table size.
  localparam logic [1:0] Width64 = 2'h2;
  localparam logic [1:0] Width32 = 2'h0;
  localparam logic [1:0] IoOnCode = 2'h3;
  localparam int LutDepth = 64;
  localparam int LutAw = 6;
endpackage : ntwtr_pkg

// ---- rtl/ntwtr_lut_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// Page table storage with a registered read port.
module ntwtr_lut_mem #(
  parameter int Depth = ntwtr_pkg::LutDepth,
  parameter int Aw = ntwtr_pkg::LutAw
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic wrEn,
  input wire logic [Aw-1:0] wrAddr,
  input wire logic [31:0] wrData,
  input wire logic [Aw-1:0] rdAddr,
  output logic [31:0] rdData
);
  logic [31:0] mem_q [Depth];

  // Entries reset to zero; only valid, prefetch and address bits are kept.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < Depth; i++) begin
        mem_q[i] <= ntwtr_pkg::ZeroWord;
      end
    end else if (wrEn) begin
      mem_q[wrAddr] <= wrData & ntwtr_pkg::MaskLut;
    end
  end

  // Read data leave through a register.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdData <= ntwtr_pkg::ZeroWord;
    end else begin
      rdData <= mem_q[rdAddr];
    end
  end
endmodule : ntwtr_lut_mem
`default_nettype wire

// ---- rtl/ntwtr_bound.sv ----
`timescale 1ns/1ps
`default_nettype none
// Effective window bound: the limit is used only if it fits the window.
module ntwtr_bound (
  input wire logic [63:0] windowSize,
  input wire logic [63:0] limit,
  output logic [63:0] bound
);
  // A limit beyond the window size is disregarded.
  always_comb begin
    if (limit > windowSize || limit == 64'h0000000000000000) begin
      bound = windowSize;
    end else begin
      bound = limit;
    end
  end
endmodule : ntwtr_bound
`default_nettype wire

// ---- rtl/ntwtr_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module ntwtr_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic upWrEn,
  input wire logic upRdEn,
  input wire logic [11:0] upAddr,
  input wire logic [31:0] upWrData,
  input wire logic ntWrEn,
  input wire logic ntRdEn,
  input wire logic [11:0] ntAddr,
  input wire logic [31:0] ntWrData,
  input wire logic curWrEn,
  input wire logic curRdEn,
  input wire logic [11:0] curAddr,
  input wire logic [31:0] curWrData,
  input wire logic romWrEn,
  input wire logic [11:0] romAddr,
  input wire logic [31:0] romWrData,
  output logic [31:0] rdData,
  output logic rdValid,
  input wire logic window_two_on,
  input wire logic window_four_on,
  input wire logic [1:0] window_four_width_select,
  input wire logic [1:0] window_four_width_select_shadow,
  input wire logic [1:0] io_window_one_on,
  input wire logic [2:0] lowPrioCount,
  input wire logic [63:0] windowTwoSize,
  input wire logic [63:0] windowFourSize,
  output logic [31:0] windowTwoXlat,
  output logic [63:0] windowFourXlat,
  output logic [63:0] windowTwoBound,
  output logic [63:0] windowFourBound,
  output logic [7:0] class_map_channel_zero,
  output logic [7:0] class_map_channel_one,
  output logic channelOneEnable,
  output logic [31:0] ioWindowOneBase,
  input wire logic [5:0] lookupIndex,
  output logic [31:0] lookupEntry
);
  logic rstSync1_q;
  logic rstN;
  logic wrEn;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic rdEn;
  logic [11:0] rdAddr;
  logic is64;
  logic ioOn;
  logic [31:0] win2Xlat_q;
  logic [31:0] win4XlatLo_q;
  logic [31:0] win4XlatHi_q;
  logic [31:0] win2Lim_q;
  logic [31:0] win4LimLo_q;
  logic [31:0] win4LimHi_q;
  logic [31:0] vc0_q;
  logic [31:0] vc1_q;
  logic [31:0] io1_q;
  logic lutWr;
  logic lutRdPend_q;
  logic [31:0] lutRdData;
  logic [31:0] regRd_d;
  logic [31:0] regRd_q;
  logic rdValid_q;
  logic [5:0] lutWrIdx;
  logic [5:0] lutRdIdx;
  logic [31:0] lutMemRd;
  logic [5:0] memRdAddr;

  // Reset release passes two flops so every register leaves reset together.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync1_q <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstN <= rstSync1_q;
    end
  end

  // Entry index from a byte address inside the table.
  function automatic logic [5:0] lutIndex(input logic [11:0] a);
    logic [11:0] d;
    d = a - ntwtr_pkg::OffLutFirst;
    return d[7:2];
  endfunction : lutIndex

  function automatic logic inLut(input logic [11:0] a);
    return a >= ntwtr_pkg::OffLutFirst && a <= ntwtr_pkg::OffLutLast && a[1:0] == 2'h0;
  endfunction : inLut

  // Write source priority: load path, upstream, non-transparent, cursor.
  // Only one write lands per cycle; lower priorities are dropped, so the
  // initialisation loader must run before software starts writing.
  always_comb begin
    if (romWrEn) begin
      wrEn = 1'b1;
      wrAddr = romAddr;
      wrData = romWrData;
    end else if (upWrEn) begin
      wrEn = 1'b1;
      wrAddr = upAddr;
      wrData = upWrData;
    end else if (ntWrEn) begin
      wrEn = 1'b1;
      wrAddr = ntAddr;
      wrData = ntWrData;
    end else begin
      wrEn = curWrEn;
      wrAddr = curAddr;
      wrData = curWrData;
    end
  end

  // Read source priority follows the same order.
  always_comb begin
    if (upRdEn) begin
      rdEn = 1'b1;
      rdAddr = upAddr;
    end else if (ntRdEn) begin
      rdEn = 1'b1;
      rdAddr = ntAddr;
    end else begin
      rdEn = curRdEn;
      rdAddr = curAddr;
    end
  end

  // Both width codes must say 64-bit before the high halves open.
  assign is64 = window_four_width_select == ntwtr_pkg::Width64 &&
                window_four_width_select_shadow == ntwtr_pkg::Width64;
  assign ioOn = io_window_one_on == ntwtr_pkg::IoOnCode;

  // Translation registers.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      win2Xlat_q <= ntwtr_pkg::ZeroWord;
      win4XlatLo_q <= ntwtr_pkg::ZeroWord;
      win4XlatHi_q <= ntwtr_pkg::ZeroWord;
    end else if (wrEn) begin
      if (wrAddr == ntwtr_pkg::OffWin2Xlat) begin
        win2Xlat_q <= wrData & ntwtr_pkg::MaskPage;
      end else if (wrAddr == ntwtr_pkg::OffWin4XlatLo) begin
        win4XlatLo_q <= wrData & ntwtr_pkg::MaskPage;
      end else if (wrAddr == ntwtr_pkg::OffWin4XlatHi && is64) begin
        win4XlatHi_q <= wrData;
      end
    end
  end

  // Limit registers.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      win2Lim_q <= ntwtr_pkg::ZeroWord;
      win4LimLo_q <= ntwtr_pkg::ZeroWord;
      win4LimHi_q <= ntwtr_pkg::ZeroWord;
    end else if (wrEn) begin
      if (wrAddr == ntwtr_pkg::OffWin2Lim) begin
        win2Lim_q <= wrData & ntwtr_pkg::MaskPage;
      end else if (wrAddr == ntwtr_pkg::OffWin4LimLo) begin
        win4LimLo_q <= wrData & ntwtr_pkg::MaskPage;
      end else if (wrAddr == ntwtr_pkg::OffWin4LimHi && is64) begin
        win4LimHi_q <= wrData;
      end
    end
  end

  // Link shadow registers; fixed bits are merged on read, not stored.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      vc0_q <= ntwtr_pkg::Vc0Reset;
      vc1_q <= ntwtr_pkg::Vc1Reset;
    end else if (wrEn) begin
      if (wrAddr == ntwtr_pkg::OffVc0Res) begin
        vc0_q <= wrData & ntwtr_pkg::MaskClassMap;
      end else if (wrAddr == ntwtr_pkg::OffVc1Res) begin
        vc1_q <= wrData & ntwtr_pkg::MaskVc1;
      end
    end
  end

  // I/O base writes only count while the window is switched on.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      io1_q <= ntwtr_pkg::ZeroWord;
    end else if (wrEn && wrAddr == ntwtr_pkg::OffIoWin1 && ioOn) begin
      io1_q <= wrData & ntwtr_pkg::MaskIoBase;
    end
  end

  // Page table: writes from the bus, reads shared with the datapath port.
  assign lutWr = wrEn && inLut(wrAddr);
  assign lutWrIdx = lutIndex(wrAddr);
  assign lutRdIdx = lutIndex(rdAddr);
  assign memRdAddr = (rdEn && inLut(rdAddr)) ? lutRdIdx : lookupIndex;

  ntwtr_lut_mem #(
    .Depth(ntwtr_pkg::LutDepth),
    .Aw(ntwtr_pkg::LutAw)
  ) u_lut (
    .clk(clk),
    .rstN(rstN),
    .wrEn(lutWr),
    .wrAddr(lutWrIdx),
    .wrData(wrData),
    .rdAddr(memRdAddr),
    .rdData(lutMemRd)
  );
  assign lutRdData = lutMemRd;

  // Register read mux; unmapped and reserved locations read zero.
  always_comb begin
    regRd_d = ntwtr_pkg::ZeroWord;
    if (rdAddr == ntwtr_pkg::OffWin2Xlat) begin
      regRd_d = win2Xlat_q;
    end else if (rdAddr == ntwtr_pkg::OffWin4XlatLo) begin
      regRd_d = win4XlatLo_q;
    end else if (rdAddr == ntwtr_pkg::OffWin4XlatHi) begin
      regRd_d = win4XlatHi_q;
    end else if (rdAddr == ntwtr_pkg::OffWin2Lim) begin
      regRd_d = win2Lim_q;
    end else if (rdAddr == ntwtr_pkg::OffWin4LimLo) begin
      regRd_d = win4LimLo_q;
    end else if (rdAddr == ntwtr_pkg::OffWin4LimHi) begin
      regRd_d = win4LimHi_q;
    end else if (rdAddr == ntwtr_pkg::OffVc0Res) begin
      regRd_d = vc0_q | ntwtr_pkg::Vc0Fixed;
    end else if (rdAddr == ntwtr_pkg::OffVc1Res) begin
      regRd_d = vc1_q;
    end else if (rdAddr == ntwtr_pkg::OffVcCap) begin
      regRd_d = {25'h0000000, lowPrioCount, 4'h0} & ntwtr_pkg::MaskVcCount;
    end else if (rdAddr == ntwtr_pkg::OffIoWin1) begin
      regRd_d = ioOn ? (io1_q | ntwtr_pkg::IoSpaceBit) : ntwtr_pkg::ZeroWord;
    end
  end

  // Read answers one cycle after the request, table or register alike.
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRd_q <= ntwtr_pkg::ZeroWord;
      lutRdPend_q <= 1'b0;
      rdValid_q <= 1'b0;
    end else begin
      regRd_q <= regRd_d;
      lutRdPend_q <= rdEn && inLut(rdAddr);
      rdValid_q <= rdEn;
    end
  end

  assign rdData = lutRdPend_q ? lutRdData : regRd_q;
  assign rdValid = rdValid_q;
  assign lookupEntry = lutRdData;

  // Datapath views of the bank.
  assign windowTwoXlat = window_two_on ? win2Xlat_q : ntwtr_pkg::ZeroWord;
  assign windowFourXlat = window_four_on ? {is64 ? win4XlatHi_q : ntwtr_pkg::ZeroWord, win4XlatLo_q}
                                         : 64'h0000000000000000;
  assign class_map_channel_zero = vc0_q[7:0] | ntwtr_pkg::Vc0Fixed[7:0];
  assign class_map_channel_one = vc1_q[7:0];
  assign channelOneEnable = vc1_q[31];
  assign ioWindowOneBase = ioOn ? io1_q : ntwtr_pkg::ZeroWord;

  ntwtr_bound u_bound2 (
    .windowSize(windowTwoSize),
    .limit({32'h00000000, win2Lim_q}),
    .bound(windowTwoBound)
  );

  ntwtr_bound u_bound4 (
    .windowSize(windowFourSize),
    .limit({is64 ? win4LimHi_q : ntwtr_pkg::ZeroWord, win4LimLo_q}),
    .bound(windowFourBound)
  );
endmodule : ntwtr_regs
`default_nettype wire

// ---- test/ntwtr_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the translation register bank.
module ntwtr_regs_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic upRdEn,
  input wire logic ntRdEn,
  input wire logic curRdEn,
  input wire logic [11:0] upAddr,
  input wire logic [31:0] rdData,
  input wire logic rdValid,
  input wire logic [1:0] window_four_width_select,
  input wire logic [1:0] window_four_width_select_shadow,
  input wire logic [1:0] io_window_one_on,
  input wire logic [63:0] windowTwoSize,
  input wire logic [31:0] windowTwoXlat,
  input wire logic [63:0] windowFourXlat,
  input wire logic [63:0] windowTwoBound,
  input wire logic [31:0] ioWindowOneBase,
  input wire logic [7:0] class_map_channel_zero,
  input wire logic [31:0] lookupEntry
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_read_answered: assert property ((upRdEn || ntRdEn || curRdEn) |=> rdValid)
    else $error("read strobe not answered");
  a_valid_has_cause: assert property (rdValid |-> $past(upRdEn || ntRdEn || curRdEn))
    else $error("read valid without a read");
  a_unmapped_zero: assert property ((upRdEn && (upAddr == 12'hC40 || upAddr == 12'hC50)) |=> rdData == 32'h00000000)
    else $error("reserved offset not zero");
  a_win2_low_zero: assert property (windowTwoXlat[11:0] == 12'h000)
    else $error("window two low bits set");
  a_win4_low_zero: assert property (windowFourXlat[11:0] == 12'h000)
    else $error("window four low bits set");
  // A 32-bit window must never carry a stored high half into the datapath view.
  a_high_locked: assert property ((window_four_width_select == 2'h0 &&
    window_four_width_select_shadow == 2'h0) |-> windowFourXlat[63:32] == 32'h00000000)
    else $error("high half visible in 32-bit mode");
  a_io_off_zero: assert property (io_window_one_on != 2'h3 |-> ioWindowOneBase == 32'h00000000)
    else $error("io base visible while off");
  a_chan0_fixed: assert property (class_map_channel_zero[0])
    else $error("class zero not on channel zero");
  a_bound_fits: assert property (windowTwoBound <= windowTwoSize)
    else $error("bound exceeds window size");
  a_entry_rsvd: assert property (lookupEntry[2:1] == 2'h0 && lookupEntry[11:4] == 8'h00)
    else $error("entry reserved bits set");
endmodule : ntwtr_regs_chk

bind ntwtr_regs ntwtr_regs_chk chk_u (
  .clk(clk),
  .arst_n(arst_n),
  .upRdEn(upRdEn),
  .ntRdEn(ntRdEn),
  .curRdEn(curRdEn),
  .upAddr(upAddr),
  .rdData(rdData),
  .rdValid(rdValid),
  .window_four_width_select(window_four_width_select),
  .window_four_width_select_shadow(window_four_width_select_shadow),
  .io_window_one_on(io_window_one_on),
  .windowTwoSize(windowTwoSize),
  .windowTwoXlat(windowTwoXlat),
  .windowFourXlat(windowFourXlat),
  .windowTwoBound(windowTwoBound),
  .ioWindowOneBase(ioWindowOneBase),
  .class_map_channel_zero(class_map_channel_zero),
  .lookupEntry(lookupEntry)
);
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, arst_n, window_two_on, window_four_on, rdValid, channelOneEnable;
  logic [11:0] aB;
  logic [31:0] dB, rdData, windowTwoXlat, ioWindowOneBase, lookupEntry;
  logic [3:0] we;
  logic [2:0] re, lowPrioCount;
  logic [1:0] window_four_width_select, window_four_width_select_shadow, io_window_one_on;
  logic [63:0] windowTwoSize, windowFourSize, windowFourXlat, windowTwoBound, windowFourBound;
  logic [5:0] lookupIndex;
  logic [7:0] class_map_channel_zero, class_map_channel_one;
  int mismatches, samples_checked;
  // All paths share address and data; the strobe vectors pick the path.
  wire logic [11:0] upAddr = aB, ntAddr = aB, curAddr = aB, romAddr = aB;
  wire logic [31:0] upWrData = dB, ntWrData = dB, curWrData = dB, romWrData = dB;
  wire logic upWrEn = we[0], ntWrEn = we[1], curWrEn = we[2], romWrEn = we[3];
  wire logic upRdEn = re[0], ntRdEn = re[1], curRdEn = re[2];
  ntwtr_regs dut_u (
    .clk(clk),
    .arst_n(arst_n),
    .upWrEn(upWrEn),
    .upRdEn(upRdEn),
    .upAddr(upAddr),
    .upWrData(upWrData),
    .ntWrEn(ntWrEn),
    .ntRdEn(ntRdEn),
    .ntAddr(ntAddr),
    .ntWrData(ntWrData),
    .curWrEn(curWrEn),
    .curRdEn(curRdEn),
    .curAddr(curAddr),
    .curWrData(curWrData),
    .romWrEn(romWrEn),
    .romAddr(romAddr),
    .romWrData(romWrData),
    .rdData(rdData),
    .rdValid(rdValid),
    .window_two_on(window_two_on),
    .window_four_on(window_four_on),
    .window_four_width_select(window_four_width_select),
    .window_four_width_select_shadow(window_four_width_select_shadow),
    .io_window_one_on(io_window_one_on),
    .lowPrioCount(lowPrioCount),
    .windowTwoSize(windowTwoSize),
    .windowFourSize(windowFourSize),
    .windowTwoXlat(windowTwoXlat),
    .windowFourXlat(windowFourXlat),
    .windowTwoBound(windowTwoBound),
    .windowFourBound(windowFourBound),
    .class_map_channel_zero(class_map_channel_zero),
    .class_map_channel_one(class_map_channel_one),
    .channelOneEnable(channelOneEnable),
    .ioWindowOneBase(ioWindowOneBase),
    .lookupIndex(lookupIndex),
    .lookupEntry(lookupEntry)
  );

  // Free-running 125 MHz clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Path 0 upstream, 1 non-transparent, 2 cursor, 3 initial load.
  task automatic wr(input int p, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 aB = a;
    dB = d;
    we = 4'h1 << p;
    @(posedge clk);
    #1 we = 4'h0;
  endtask : wr

  // The answer is looked at just after the edge that follows the strobe.
  task automatic rd(input int p, input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    #1 aB = a;
    re = 3'h1 << p;
    @(posedge clk);
    #1 re = 3'h0;
    chk({63'h0, rdValid}, 64'h1);
    chk({32'h0, rdData}, {32'h0, e});
  endtask : rd

  task automatic t_reset;
    rd(0, 12'hC3C, 32'h00000000);
    rd(1, 12'hC5C, 32'h00000000);
    rd(2, 12'hD5C, 32'h800000FF);
    rd(0, 12'hD60, 32'h01000000);
    rd(0, 12'hD64, 32'h00000050);
  endtask : t_reset

  task automatic t_masks;
    logic [11:0] a [6] = '{12'hC3C, 12'hC44, 12'hC4C, 12'hC54, 12'hC40, 12'hC50};
    for (int i = 0; i < 6; i++) begin
      wr(i % 2, a[i], 32'hFFFFFFFF);
      rd(1 - i % 2, a[i], i < 4 ? 32'hFFFFF000 : 32'h00000000);
    end
    chk({32'h0, windowTwoXlat}, 64'hFFFFF000);
    chk(windowTwoBound, 64'h100000);
    wr(0, 12'hC4C, 32'h00080000);
    chk(windowTwoBound, 64'h80000);
    {window_two_on, window_four_on} = 2'h0;
    @(posedge clk);
    #1 chk({32'h0, windowTwoXlat}, 64'h0);
    chk(windowFourXlat, 64'h0);
    {window_two_on, window_four_on} = 2'h3;
  endtask : t_masks

  task automatic t_high;
    wr(0, 12'hC48, 32'hA5A5A5A5);
    wr(1, 12'hC58, 32'h5A5A5A5A);
    rd(0, 12'hC48, 32'h00000000);
    rd(1, 12'hC58, 32'h00000000);
    window_four_width_select = 2'h2;
    window_four_width_select_shadow = 2'h2;
    wr(0, 12'hC48, 32'hA5A5A5A5);
    wr(1, 12'hC58, 32'h5A5A5A5A);
    rd(1, 12'hC48, 32'hA5A5A5A5);
    rd(0, 12'hC58, 32'h5A5A5A5A);
    chk(windowFourXlat, 64'hA5A5A5A5FFFFF000);
    chk(windowFourBound, 64'h100000);
    window_four_width_select = 2'h0;
    window_four_width_select_shadow = 2'h0;
  endtask : t_high

  task automatic t_lut;
    wr(0, 12'hC5C, 32'hFFFFFFFF);
    wr(1, 12'hD58, 32'h12345678);
    wr(2, 12'hC60, 32'hFFFFFFFF);
    rd(2, 12'hC5C, 32'hFFFFF009);
    rd(0, 12'hD58, 32'h12345008);
    rd(1, 12'hC60, 32'hFFFFF009);
    lookupIndex = 6'h3F;
    repeat (2) @(posedge clk);
    #1 chk({32'h0, lookupEntry}, 64'h12345008);
    wr(3, 12'hC60, 32'h00000000);
    rd(2, 12'hC60, 32'h00000000);
  endtask : t_lut

  task automatic t_shadows;
    wr(0, 12'hD5C, 32'h00000000);
    rd(0, 12'hD5C, 32'h80000001);
    chk({56'h0, class_map_channel_zero}, 64'h1);
    wr(1, 12'hD60, 32'hFFFFFFFF);
    rd(1, 12'hD60, 32'h810000FE);
    chk({63'h0, channelOneEnable}, 64'h1);
    chk({56'h0, class_map_channel_one}, 64'hFE);
    wr(0, 12'hD64, 32'hFFFFFFFF);
    rd(0, 12'hD64, 32'h00000050);
    wr(0, 12'hD6C, 32'hFFFFFFFF);
    rd(0, 12'hD6C, 32'h00000000);
    io_window_one_on = 2'h3;
    wr(0, 12'hD6C, 32'hFFFFFFFF);
    rd(1, 12'hD6C, 32'hFFFFFF01);
    chk({32'h0, ioWindowOneBase}, 64'hFFFFFF00);
    wr(3, 12'hC3C, 32'h12345678);
    rd(0, 12'hC3C, 32'h12345000);
  endtask : t_shadows

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  // Main sequence: reset held three cycles, then three edges of settling.
  initial begin
    {arst_n, aB, dB, we, re, lookupIndex} = '0;
    {window_four_width_select, window_four_width_select_shadow, io_window_one_on} = '0;
    {window_two_on, window_four_on, lowPrioCount} = {2'h3, 3'h5};
    windowTwoSize = 64'h100000;
    windowFourSize = 64'h100000;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_masks();
    t_high();
    t_lut();
    t_shadows();
    conclude();
  end

  // The run needs under a microsecond; the 50 us limit is far longer and means a hang.
  initial begin
    #50000;
    mismatches++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
